// File: hdl/charge_pkg.sv
package charge_pkg;

	// Charge cycle states, one per documented mode
	typedef enum logic [2:0] {
		ST_SHUTDOWN,
		ST_NO_BATTERY,
		ST_PRECONDITION,
		ST_CONST_CURRENT,
		ST_CONST_VOLTAGE,
		ST_COMPLETE
	} charge_state_t;

	// Comparator flags from the analog front end
	typedef struct packed {
		logic undervoltage_lockout;   // Supply below lockout level, hysteresis applied in analog
		logic headroom_ok;            // Supply at least 150 mV above battery
		logic headroom_lost;          // Supply within 50 mV of battery
		logic battery_absent;         // Output at regulation_voltage plus detect margin
		logic below_precondition;     // Battery below trickle threshold
		logic at_regulation;          // Battery reached regulation_voltage
		logic below_recharge;         // Battery below recharge threshold
		logic below_termination;      // Averaged current below end-of-charge fraction
		logic over_temperature;       // Die above shutdown temperature, hysteresis in analog
	} sense_t;

	// Current request to the pass-transistor loop
	typedef enum logic [1:0] {
		REQ_OFF,
		REQ_TRICKLE,
		REQ_FULL
	} current_req_t;

	typedef struct packed {
		logic         charge_on;
		current_req_t level;
		logic         thermal_limit;
	} drive_t;

	localparam int unsigned CLK_FREQ_HZ           = 25_000_000;
	localparam int unsigned TERM_FILTER_US        = 1000;
	localparam int unsigned TERM_FILTER_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * TERM_FILTER_US;
	localparam int unsigned SYNC_STAGES           = 2;
	localparam int unsigned SENSE_WIDTH           = $bits(sense_t);
	localparam logic        OPEN_DRAIN_DEFAULT    = 1'b0;
	localparam logic [1:0]  REG_VOLTAGE_OPT_DEF   = 2'h0;

endpackage

// File: hdl/input_sync.sv
module input_sync #(
	parameter int unsigned WIDTH  = 1,
	parameter int unsigned STAGES = 2
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	input  wire logic [WIDTH-1:0] reset_value,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage_reg [STAGES];

	// Only the last stage leaves this module; earlier stages feed the next flop alone
	genvar g;
	generate
		for (g = 0; g < STAGES; g++) begin : g_stage
			always_ff @(posedge clk_sys) begin
				if (!reset_n)
					stage_reg[g] <= '0;
				else if (g == 0)
					stage_reg[g] <= async_in;
				else
					stage_reg[g] <= stage_reg[(g == 0) ? 0 : g - 1];
			end
		end
	endgenerate

	// Before the chain fills after reset, report the safe value
	logic [STAGES-1:0] fill_reg;
	always_ff @(posedge clk_sys) begin
		if (!reset_n)
			fill_reg <= '0;
		else
			fill_reg <= {fill_reg[STAGES-2:0], 1'b1};
	end

	assign sync_out = fill_reg[STAGES-1] ? stage_reg[STAGES-1] : reset_value;
endmodule // input_sync

// File: hdl/liion_charge_sequencer.sv
// Contract
// - Undervoltage lockout holds charger in Shutdown
// - Start needs 150 mV supply headroom
// - Headroom under 50 mV forces Shutdown
// - Lockout checked always, overrides every state
// - Output above detect margin means no battery
// - Output below detect margin means battery present
// - Charge starts only when fully qualified
// - Open current_set_pin keeps charger disabled
// - Low battery at start enters preconditioning
// - Preconditioning requests trickle fraction of current
// - Above threshold, preconditioning moves to fast charge
// - Fast charge holds full current until regulation
// - Regulation reached enters constant voltage mode
// - Terminate after current low for 1 ms
// - Termination latches current off, Charge Complete
// - Complete state recharges below recharge threshold
// - Over-temperature suspends charging until cooled
// - Thermal input reduces requested current
// - Status pin pattern per state and variant
// - Enable toggles anytime; re-enable requalifies
module liion_charge_sequencer
	import charge_pkg::*;
#(
	parameter logic        OPEN_DRAIN      = charge_pkg::OPEN_DRAIN_DEFAULT,
	parameter int unsigned TERM_CYCLES     = charge_pkg::TERM_FILTER_CYCLES,
	parameter logic [1:0]  REG_VOLTAGE_OPT = charge_pkg::REG_VOLTAGE_OPT_DEF
) (
	input  wire logic                   clk_sys,
	input  wire logic                   reset_n,
	input  wire charge_pkg::sense_t     sense_in,
	input  wire logic                   current_set_pin,
	input  wire logic                   thermal_regulation,
	output charge_pkg::drive_t          drive_out,
	output charge_pkg::charge_state_t   state_out,
	output logic [1:0]                  regulation_voltage_sel,
	output logic                        status_out,
	output logic                        status_oe
);
	import charge_pkg::*;

	localparam int unsigned SYNC_W = SENSE_WIDTH + 2;
	localparam int unsigned CNT_W  = $clog2(TERM_CYCLES + 1);

	// Safe values until synchronisers fill: lockout asserted, pin disabled
	localparam sense_t SENSE_SAFE = '{undervoltage_lockout: 1'b1, headroom_ok: 1'b0, headroom_lost: 1'b1,
		battery_absent: 1'b1, below_precondition: 1'b1, at_regulation: 1'b0, below_recharge: 1'b0,
		below_termination: 1'b0, over_temperature: 1'b1};

	logic [SYNC_W-1:0] sync_raw;
	sense_t            s;
	logic              pin_high;
	logic              therm_sync;

	input_sync #(
		.WIDTH  (SYNC_W),
		.STAGES (SYNC_STAGES)
	) u_sync (
		.clk_sys     (clk_sys),
		.reset_n     (reset_n),
		.async_in    ({sense_in, current_set_pin, thermal_regulation}),
		.reset_value ({SENSE_SAFE, 1'b1, 1'b0}),
		.sync_out    (sync_raw)
	);

	assign s          = sense_t'(sync_raw[SYNC_W-1:2]);
	assign pin_high   = sync_raw[1];
	assign therm_sync = sync_raw[0];

	charge_state_t     state_reg;
	charge_state_t     state_next;
	logic              armed_reg;
	logic              armed_next;
	logic [CNT_W-1:0]  term_cnt_reg;
	logic [CNT_W-1:0]  term_cnt_next;
	logic              term_done;

	// A lost headroom disarms until the 150 mV level is seen again
	wire lockout   = s.undervoltage_lockout | s.headroom_lost | !armed_reg;
	// Pin floating or driven high reads as logic high
	wire disabled  = pin_high;
	wire battery_ok = !s.battery_absent;
	wire qualified = !lockout && !disabled && battery_ok;
	wire suspend   = s.over_temperature;
	wire charging  = (state_reg == ST_PRECONDITION) || (state_reg == ST_CONST_CURRENT) ||
		(state_reg == ST_CONST_VOLTAGE);

	always_comb begin
		armed_next = armed_reg;
		if (s.undervoltage_lockout || s.headroom_lost)
			armed_next = 1'b0;
		else if (s.headroom_ok)
			armed_next = 1'b1;
	end

	// Filter counts only while averaged current stays low in CV mode
	assign term_done = (term_cnt_reg == CNT_W'(TERM_CYCLES));

	always_comb begin
		term_cnt_next = '0;
		if (state_reg == ST_CONST_VOLTAGE && s.below_termination && !suspend)
			term_cnt_next = term_done ? term_cnt_reg : term_cnt_reg + CNT_W'(1);
	end

	function automatic charge_state_t entry_state(input sense_t f);
		entry_state = f.below_precondition ? ST_PRECONDITION :
			(f.at_regulation ? ST_CONST_VOLTAGE : ST_CONST_CURRENT);
	endfunction

	always_comb begin
		state_next = state_reg;
		if (lockout || disabled) begin
			state_next = ST_SHUTDOWN;
		end else if (!battery_ok) begin
			state_next = ST_NO_BATTERY;
		end else begin
			unique case (state_reg)
				ST_SHUTDOWN, ST_NO_BATTERY: begin
					// Re-enable always starts a fresh qualified cycle
					if (qualified)
						state_next = entry_state(s);
				end
				ST_PRECONDITION: begin
					if (!s.below_precondition)
						state_next = ST_CONST_CURRENT;
				end
				ST_CONST_CURRENT: begin
					if (s.at_regulation)
						state_next = ST_CONST_VOLTAGE;
				end
				ST_CONST_VOLTAGE: begin
					if (term_done)
						state_next = ST_COMPLETE;
				end
				ST_COMPLETE: begin
					if (s.below_recharge)
						state_next = entry_state(s);
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_reg    <= ST_SHUTDOWN;
			armed_reg    <= 1'b0;
			term_cnt_reg <= '0;
		end else begin
			state_reg    <= state_next;
			armed_reg    <= armed_next;
			term_cnt_reg <= term_cnt_next;
		end
	end

	// Drive and status come from flops so they never glitch on input changes
	drive_t drive_next;
	logic   stat_next;
	logic   stat_oe_next;

	always_comb begin
		// Taken from the next state so the current request moves on the same edge as state_out
		drive_next.charge_on     = (state_next inside {ST_PRECONDITION, ST_CONST_CURRENT, ST_CONST_VOLTAGE}) &&
			!suspend;
		drive_next.thermal_limit = drive_next.charge_on && therm_sync;
		if (!drive_next.charge_on)
			drive_next.level = REQ_OFF;
		else if (state_next == ST_PRECONDITION)
			drive_next.level = REQ_TRICKLE;
		else
			drive_next.level = REQ_FULL;
		if (!(state_next inside {ST_PRECONDITION, ST_CONST_CURRENT, ST_CONST_VOLTAGE}))
			drive_next = '{charge_on: 1'b0, level: REQ_OFF, thermal_limit: 1'b0};
		stat_next    = 1'b0;
		stat_oe_next = 1'b0;
		unique case (state_next)
			ST_PRECONDITION, ST_CONST_CURRENT, ST_CONST_VOLTAGE: begin
				stat_next    = 1'b0;
				stat_oe_next = 1'b1;
			end
			ST_COMPLETE: begin
				stat_next    = 1'b1;
				stat_oe_next = !OPEN_DRAIN;
			end
			default: begin
				stat_next    = 1'b0;
				stat_oe_next = 1'b0;
			end
		endcase
	end

	drive_t drive_reg;
	logic   stat_reg;
	logic   stat_oe_reg;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			drive_reg   <= '{charge_on: 1'b0, level: REQ_OFF, thermal_limit: 1'b0};
			stat_reg    <= 1'b0;
			stat_oe_reg <= 1'b0;
		end else begin
			drive_reg   <= drive_next;
			stat_reg    <= stat_next;
			stat_oe_reg <= stat_oe_next;
		end
	end

	assign drive_out              = drive_reg;
	assign state_out              = state_reg;
	assign status_out             = stat_reg;
	assign status_oe              = stat_oe_reg;
	assign regulation_voltage_sel = REG_VOLTAGE_OPT;
endmodule // liion_charge_sequencer

// File: testbench/charge_assertions.sv
module charge_assertions
	import charge_pkg::*;
#(
	parameter logic        OPEN_DRAIN  = 1'b0,
	parameter int unsigned TERM_CYCLES = 8
) (
	input wire logic                        clk_sys,
	input wire logic                        reset_n,
	input wire charge_pkg::sense_t          sense_in,
	input wire logic                        thermal_regulation,
	input wire logic                        current_set_pin,
	input wire charge_pkg::drive_t          drive_out,
	input wire charge_pkg::charge_state_t   state_out,
	input wire logic                        status_out,
	input wire logic                        status_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	int unsigned term_cnt;
	wire charging = state_out inside {ST_PRECONDITION, ST_CONST_CURRENT, ST_CONST_VOLTAGE};
	wire idle = state_out inside {ST_SHUTDOWN, ST_NO_BATTERY};
	// Run length of the raw end-of-charge flag, before synchronising
	always_ff @(posedge clk_sys) term_cnt <= sense_in.below_termination ? term_cnt + 1 : 0;

	a_lockout_to_off: assert property (sense_in.undervoltage_lockout[*3] |=> state_out == ST_SHUTDOWN)
		else $error("lockout did not force shutdown");
	a_headroom_to_off: assert property (sense_in.headroom_lost[*3] |=> state_out == ST_SHUTDOWN)
		else $error("lost headroom did not force shutdown");
	a_disable_to_off: assert property (current_set_pin[*3] |=> state_out == ST_SHUTDOWN)
		else $error("disabled charger left shutdown");
	a_status_charging: assert property (charging |-> status_oe && !status_out)
		else $error("status not low while charging");
	a_status_idle: assert property (idle |-> !status_oe)
		else $error("status driven while idle");
	a_status_done: assert property (state_out == ST_COMPLETE |-> status_oe == !OPEN_DRAIN && (OPEN_DRAIN || status_out))
		else $error("wrong status in charge complete");
	a_trickle_level: assert property (state_out == ST_PRECONDITION && drive_out.charge_on |-> drive_out.level == REQ_TRICKLE)
		else $error("preconditioning level wrong");
	a_full_level: assert property (state_out == ST_CONST_CURRENT && drive_out.charge_on |-> drive_out.level == REQ_FULL)
		else $error("fast charge level wrong");
	a_complete_off: assert property (!charging |-> !drive_out.charge_on)
		else $error("current on outside charging");
	a_term_filter: assert property ($rose(state_out == ST_COMPLETE) |-> term_cnt >= TERM_CYCLES)
		else $error("termination before filter time");
	a_overtemp_off: assert property (sense_in.over_temperature[*3] |=> !drive_out.charge_on)
		else $error("charging during over temperature");
	a_thermal_limit: assert property (thermal_regulation[*3] ##1 drive_out.charge_on |-> drive_out.thermal_limit)
		else $error("thermal limit not requested");
endmodule // charge_assertions

// File: testbench/status_host_model.sv
module status_host_model (
	input  wire logic status_out,
	input  wire logic status_oe,
	input  wire logic enable_req,
	output logic      current_set_pin,
	output logic      led_on
);
	timeunit 1ns;
	timeprecision 1ps;
	// Host pull-up decides the level when the pin is released
	wire stat_level = status_oe ? status_out : 1'b1;
	assign led_on = !stat_level;
	// Released pin floats high and disables charging
	assign current_set_pin = enable_req ? 1'b0 : 1'b1;
endmodule // status_host_model

// File: testbench/testbench.sv
module testbench;
	import charge_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, reset_n = 0, en = 0, thermal_regulation = 0, status_out, status_oe, current_set_pin, led_on;
	sense_t sense_in = 9'h100;
	drive_t drive_out;
	charge_state_t state_out;
	logic [8:0] notes[$], last = 0;
	logic [1:0] reg_sel;
	int fails = 0, n_tests = 0;
	wire [8:0] obs = {state_out, drive_out, status_oe, status_out};
	liion_charge_sequencer #(.OPEN_DRAIN(1'b0), .TERM_CYCLES(8)) liion_charge_sequencer_inst (.clk_sys(clk_sys),
		.reset_n(reset_n), .sense_in(sense_in), .current_set_pin(current_set_pin),
		.thermal_regulation(thermal_regulation), .drive_out(drive_out), .state_out(state_out),
		.regulation_voltage_sel(reg_sel), .status_out(status_out), .status_oe(status_oe));
	status_host_model status_host_model_inst (.status_out(status_out), .status_oe(status_oe),
		.enable_req(en), .current_set_pin(current_set_pin), .led_on(led_on));
	initial forever #20 clk_sys = !clk_sys;
	function automatic logic [8:0] exp_of(charge_state_t s, logic th);
		logic [1:0] lv;
		lv = s == ST_PRECONDITION ? REQ_TRICKLE : (s inside {ST_CONST_CURRENT, ST_CONST_VOLTAGE}) ? REQ_FULL : REQ_OFF;
		return {s, lv != 0, lv, th, s >= ST_PRECONDITION, s == ST_COMPLETE};
	endfunction
	task automatic check(input logic [8:0] seen, input logic [8:0] want);
		n_tests++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic note(input charge_state_t s, input string name);
		notes.push_back(exp_of(s, 1'b0));
		tick(8);
		$display("test %s done", name);
		tick(1);
	endtask
	task automatic finish_test;
		if (notes.size() != 0) fails++;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(negedge clk_sys) begin
		if (reset_n && obs !== last) check(obs, notes.size() ? notes.pop_front() : 9'h1ff);
		last = obs;
	end
	initial begin
		#80000;
		fails++;
		finish_test;
	end
	initial begin
		void'($urandom(32'h3bba));
		tick(6);
		reset_n <= 1;
		sense_in.undervoltage_lockout <= 0;
		en <= 1;
		sense_in.below_precondition <= 1;
		tick(9); // no headroom yet: nothing may change
		check({7'h0, reg_sel}, {7'h0, REG_VOLTAGE_OPT_DEF});
		sense_in.headroom_ok <= 1;
		note(ST_PRECONDITION, "trickle");
		sense_in.below_precondition <= 0;
		sense_in.below_recharge <= 1'($urandom);
		note(ST_CONST_CURRENT, "fast");
		thermal_regulation <= 1;
		notes.push_back(exp_of(ST_CONST_CURRENT, 1'b1));
		tick(8);
		thermal_regulation <= 0;
		notes.push_back(exp_of(ST_CONST_CURRENT, 1'b0));
		tick(8);
		sense_in.at_regulation <= 1;
		note(ST_CONST_VOLTAGE, "regulate");
		sense_in.below_recharge <= 0;
		sense_in.below_termination <= 1;
		tick(5);
		sense_in.below_termination <= 0;
		tick(12); // short dip must not end the charge
		sense_in.below_termination <= 1;
		note(ST_COMPLETE, "terminate");
		tick(12);
		sense_in.below_termination <= 0;
		sense_in.below_recharge <= 1;
		note(ST_CONST_VOLTAGE, "recharge");
		sense_in.below_recharge <= 0;
		sense_in.headroom_ok <= 0;
		sense_in.headroom_lost <= 1;
		note(ST_SHUTDOWN, "headroom lost");
		sense_in.headroom_lost <= 0;
		tick(9);
		sense_in.headroom_ok <= 1;
		note(ST_CONST_VOLTAGE, "rearm");
		en <= 0;
		note(ST_SHUTDOWN, "disable");
		en <= 1;
		note(ST_CONST_VOLTAGE, "enable");
		sense_in.battery_absent <= 1;
		note(ST_NO_BATTERY, "absent");
		sense_in.battery_absent <= 0;
		note(ST_CONST_VOLTAGE, "present");
		sense_in.over_temperature <= 1;
		notes.push_back({ST_CONST_VOLTAGE, 6'h02});
		tick(8);
		sense_in.over_temperature <= 0;
		note(ST_CONST_VOLTAGE, "hot");
		sense_in.undervoltage_lockout <= 1;
		note(ST_SHUTDOWN, "lockout");
		finish_test;
	end
endmodule // testbench

bind liion_charge_sequencer charge_assertions #(.OPEN_DRAIN(OPEN_DRAIN), .TERM_CYCLES(TERM_CYCLES)) charge_assertions_inst (
	.clk_sys(clk_sys), .reset_n(reset_n), .sense_in(sense_in), .thermal_regulation(thermal_regulation),
	.current_set_pin(current_set_pin), .drive_out(drive_out), .state_out(state_out),
	.status_out(status_out), .status_oe(status_oe));
